// ==== const_ops_pkg.sv ====
package const_ops_pkg;

    localparam int CONST_W = 16;
    localparam int IMM_W = 5;
    localparam int DATA_W = 32;
    localparam int LONG_W = 40;
    localparam int PAD_W = LONG_W - DATA_W;
    localparam int OPF_W = 7;
    localparam int OPF_S_W = 6;
    localparam int IDLE_W = 4;
    localparam int NORM_W = 6;

    // Largest idle field: a count of nine cycles, stored as count - 1.
    localparam logic [IDLE_W-1:0] IDLE_MAX_FIELD = 4'h8;
    localparam logic [IDLE_W-1:0] IDLE_ONE_FIELD = 4'h0;

    localparam logic [DATA_W-1:0] ALL_ONES32 = 32'hFFFF_FFFF;
    localparam logic [DATA_W-1:0] INT32_MAX = 32'h7FFF_FFFF;
    localparam logic [DATA_W-1:0] INT32_MIN = 32'h8000_0000;
    localparam logic [DATA_W-1:0] ZERO32 = 32'h0000_0000;
    localparam logic [LONG_W-1:0] ZERO40 = 40'h00_0000_0000;
    localparam logic [NORM_W-1:0] NORM32_MAX = 6'h1F;

    // Logic unit operation fields.
    localparam logic [OPF_W-1:0] OPF_L_NEG32 = 7'h06;
    localparam logic [OPF_W-1:0] OPF_L_NEG40 = 7'h24;
    localparam logic [OPF_W-1:0] OPF_L_NORM32 = 7'h63;
    localparam logic [OPF_W-1:0] OPF_L_NORM40 = 7'h60;
    localparam logic [OPF_W-1:0] OPF_L_OR_REG = 7'h7F;
    localparam logic [OPF_W-1:0] OPF_L_OR_IMM = 7'h7E;
    localparam logic [OPF_W-1:0] OPF_L_SADD32 = 7'h13;
    localparam logic [OPF_W-1:0] OPF_L_SADD40 = 7'h31;
    localparam logic [OPF_W-1:0] OPF_L_SATURATING_ADD_OP_IMM32 = 7'h12;
    localparam logic [OPF_W-1:0] OPF_L_SATURATING_ADD_OP_IMM40 = 7'h30;
    localparam logic [OPF_W-1:0] OPF_L_SAT = 7'h40;

    // Shift unit operation fields.
    localparam logic [OPF_S_W-1:0] OPF_S_OR_REG = 6'h1B;
    localparam logic [OPF_S_W-1:0] OPF_S_OR_IMM = 6'h1A;
    localparam logic [OPF_S_W-1:0] OPF_S_NEG32 = 6'h16;

    typedef enum logic [2:0] {
        CLASS_NONE = 3'b000,
        CLASS_LOGIC = 3'b001,
        CLASS_SHIFT = 3'b010,
        CLASS_LOAD_LOW = 3'b011,
        CLASS_NOT = 3'b100
    } op_class_t;

    typedef enum logic {
        IDLE_OFF = 1'b0,
        IDLE_RUN = 1'b1
    } idle_state_t;

endpackage

// ==== sat_adder.sv ====
`timescale 1ns/1ps
module sat_adder #(
    parameter int W = 40
) (
    input wire logic [W-1:0] a,
    input wire logic [W-1:0] b,
    output logic [W-1:0] sum,
    output logic sat
);

    logic [W:0] wide;

    // One guard bit shows overflow when it disagrees with the sign bit.
    always_comb begin
        wide = {a[W-1], a} + {b[W-1], b};
        sat = wide[W] ^ wide[W-1];
        if (!sat) begin
            sum = wide[W-1:0];
        end else if (wide[W]) begin
            sum = {1'b1, {(W-1){1'b0}}};
        end else begin
            sum = {1'b0, {(W-1){1'b1}}};
        end
    end

endmodule

// ==== norm_counter.sv ====
`timescale 1ns/1ps
module norm_counter #(
    parameter int W = 40
) (
    input wire logic [W-1:0] value,
    output logic [5:0] count
);

    logic done;

    // Counts the bits below the sign bit that merely repeat it.
    always_comb begin
        count = 6'h00;
        done = 1'b0;
        for (int i = W - 2; i >= 0; i--) begin
            if (!done && value[i] == value[W-1]) begin
                count = count + 6'h01;
            end else begin
                done = 1'b1;
            end
        end
    end

endmodule

// ==== const_logic_sat_ops.sv ====
`timescale 1ns/1ps
// Summary of operation
// - Low-constant load sign-extends the 16-bit field to 32 bits.
// - Low-constant load writes its destination in one cycle.
// - Negate writes zero minus source, 32-bit and 40-bit forms.
// - Idle field holds count minus one; idle lasts field plus one.
// - Idle counts above nine are flagged unsupported.
// - Idle with a zero field is a single-cycle idle.
// - A completing branch ends a multi-cycle idle early.
// - A single-cycle idle leaves parallel instructions untouched.
// - Normalize writes the number of redundant sign bits.
// - Normalize completes in one cycle.
// - Bitwise NOT writes source XOR all ones.
// - Bitwise OR; a 5-bit immediate is sign-extended first.
// - Saturating add clamps on overflow, two forms listed.
// - 32-bit saturating add clamps to the signed 32-bit range.
// - 40-bit saturating add clamps to the signed 40-bit range.
// - Saturate converts 40-bit to 32-bit with clamping.
// - A clamp sets the saturation flag a cycle after the write.
module const_logic_sat_ops
    import const_ops_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic issue_valid,
    input wire logic cond_pass,
    input wire op_class_t op_class,
    input wire logic [OPF_W-1:0] opfield,
    input wire logic [DATA_W-1:0] src1,
    input wire logic [LONG_W-1:0] src2,
    input wire logic [CONST_W-1:0] cst16,
    input wire logic [IMM_W-1:0] imm5,
    input wire logic idle_valid,
    input wire logic [IDLE_W-1:0] idle_field,
    input wire logic branch_done,
    input wire logic sat_flag_clear,
    output logic wr_en,
    output logic wr_long,
    output logic [LONG_W-1:0] wr_data,
    output logic sat_flag,
    output logic idle_busy,
    output logic idle_unsupported
);

    ////////////////////////////////////////////////////////////////////////
    // Operand shaping.

    logic [DATA_W-1:0] cst_sext;
    logic [DATA_W-1:0] imm32;
    logic [LONG_W-1:0] imm40;
    logic [LONG_W-1:0] src1_long;
    logic [DATA_W-1:0] src2_lo;

    assign cst_sext = {{(DATA_W-CONST_W){cst16[CONST_W-1]}}, cst16};
    assign imm32 = {{(DATA_W-IMM_W){imm5[IMM_W-1]}}, imm5};
    assign imm40 = {{(LONG_W-IMM_W){imm5[IMM_W-1]}}, imm5};
    assign src1_long = {{PAD_W{src1[DATA_W-1]}}, src1};
    assign src2_lo = src2[DATA_W-1:0];

    ////////////////////////////////////////////////////////////////////////
    // Saturating adders and sign-bit counters.

    logic [DATA_W-1:0] add_a32;
    logic [LONG_W-1:0] add_a40;
    logic [DATA_W-1:0] sum32;
    logic [LONG_W-1:0] sum40;
    logic sat32;
    logic sat40;
    logic [NORM_W-1:0] norm32;
    logic [NORM_W-1:0] norm40;

    assign add_a32 = (opfield == OPF_L_SATURATING_ADD_OP_IMM32) ? imm32 : src1;
    assign add_a40 = (opfield == OPF_L_SATURATING_ADD_OP_IMM40) ? imm40 : src1_long;

    sat_adder #(.W(DATA_W)) add32 (
        .a(add_a32),
        .b(src2_lo),
        .sum(sum32),
        .sat(sat32)
    );

    sat_adder #(.W(LONG_W)) add40 (
        .a(add_a40),
        .b(src2),
        .sum(sum40),
        .sat(sat40)
    );

    norm_counter #(.W(DATA_W)) count32 (
        .value(src2_lo),
        .count(norm32)
    );

    norm_counter #(.W(LONG_W)) count40 (
        .value(src2),
        .count(norm40)
    );

    ////////////////////////////////////////////////////////////////////////
    // Long to int saturation.

    logic long_fits;
    logic [DATA_W-1:0] sat_result;

    // The value fits when every bit above bit 31 copies bit 31.
    assign long_fits = (&src2[LONG_W-1:DATA_W-1])
        | ~(|src2[LONG_W-1:DATA_W-1]);
    assign sat_result = long_fits ? src2_lo
        : (src2[LONG_W-1] ? INT32_MIN : INT32_MAX);

    ////////////////////////////////////////////////////////////////////////
    // Result selection.

    logic next_wr_en;
    logic next_wr_long;
    logic [LONG_W-1:0] next_wr_data;
    logic next_sat;

    always_comb begin
        next_wr_en = 1'b0;
        next_wr_long = 1'b0;
        next_wr_data = ZERO40;
        next_sat = 1'b0;
        if (issue_valid && cond_pass) begin
            unique case (op_class)
                CLASS_LOAD_LOW: begin
                    next_wr_en = 1'b1;
                    next_wr_data = {{PAD_W{1'b0}}, cst_sext};
                end
                CLASS_NOT: begin
                    next_wr_en = 1'b1;
                    next_wr_data = {{PAD_W{1'b0}}, src2_lo ^ ALL_ONES32};
                end
                CLASS_SHIFT: begin
                    next_wr_en = 1'b1;
                    case (opfield[OPF_S_W-1:0])
                        OPF_S_OR_REG: begin
                            next_wr_data = {{PAD_W{1'b0}}, src1 | src2_lo};
                        end
                        OPF_S_OR_IMM: begin
                            next_wr_data = {{PAD_W{1'b0}}, imm32 | src2_lo};
                        end
                        OPF_S_NEG32: begin
                            next_wr_data = {{PAD_W{1'b0}}, ZERO32 - src2_lo};
                        end
                        default: begin
                            next_wr_en = 1'b0;
                        end
                    endcase
                end
                CLASS_LOGIC: begin
                    next_wr_en = 1'b1;
                    case (opfield)
                        OPF_L_NEG32: begin
                            next_wr_data = {{PAD_W{1'b0}}, ZERO32 - src2_lo};
                        end
                        OPF_L_NEG40: begin
                            next_wr_long = 1'b1;
                            next_wr_data = ZERO40 - src2;
                        end
                        OPF_L_NORM32: begin
                            next_wr_data = {{(LONG_W-NORM_W){1'b0}}, norm32};
                        end
                        OPF_L_NORM40: begin
                            next_wr_data = {{(LONG_W-NORM_W){1'b0}}, norm40};
                        end
                        OPF_L_OR_REG: begin
                            next_wr_data = {{PAD_W{1'b0}}, src1 | src2_lo};
                        end
                        OPF_L_OR_IMM: begin
                            next_wr_data = {{PAD_W{1'b0}}, imm32 | src2_lo};
                        end
                        OPF_L_SADD32, OPF_L_SATURATING_ADD_OP_IMM32: begin
                            next_wr_data = {{PAD_W{1'b0}}, sum32};
                            next_sat = sat32;
                        end
                        OPF_L_SADD40, OPF_L_SATURATING_ADD_OP_IMM40: begin
                            next_wr_long = 1'b1;
                            next_wr_data = sum40;
                            next_sat = sat40;
                        end
                        OPF_L_SAT: begin
                            next_wr_data = {{PAD_W{1'b0}}, sat_result};
                            next_sat = ~long_fits;
                        end
                        default: begin
                            next_wr_en = 1'b0;
                        end
                    endcase
                end
                default: begin
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Destination write, one cycle after issue.

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wr_en <= 1'b0;
            wr_long <= 1'b0;
            wr_data <= ZERO40;
        end else begin
            wr_en <= next_wr_en;
            wr_long <= next_wr_long;
            wr_data <= next_wr_data;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Saturation flag.

    logic sat_pending;

    // The clamp is noted with the write and posted one cycle later.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sat_pending <= 1'b0;
        end else begin
            sat_pending <= next_wr_en & next_sat;
        end
    end

    // A posting clamp wins over a clear in the same cycle.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sat_flag <= 1'b0;
        end else if (sat_pending) begin
            sat_flag <= 1'b1;
        end else if (sat_flag_clear) begin
            sat_flag <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Multi-cycle idle.

    idle_state_t idle_state;
    logic [IDLE_W-1:0] idle_left;

    // The issue cycle is the first idle cycle, so busy covers the rest.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            idle_state <= IDLE_OFF;
            idle_left <= IDLE_ONE_FIELD;
            idle_busy <= 1'b0;
            idle_unsupported <= 1'b0;
        end else begin
            idle_unsupported <= 1'b0;
            unique case (idle_state)
                IDLE_OFF: begin
                    if (idle_valid) begin
                        if (idle_field > IDLE_MAX_FIELD) begin
                            idle_unsupported <= 1'b1;
                        end else if (idle_field != IDLE_ONE_FIELD) begin
                            idle_state <= IDLE_RUN;
                            idle_busy <= 1'b1;
                            idle_left <= idle_field - 4'h1;
                        end
                        // A zero field stalls nothing.
                    end
                end
                IDLE_RUN: begin
                    if (branch_done || idle_left == IDLE_ONE_FIELD) begin
                        idle_state <= IDLE_OFF;
                        idle_busy <= 1'b0;
                    end else begin
                        idle_left <= idle_left - 4'h1;
                    end
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Checks.

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);

    logic [IDLE_W-1:0] busy_run;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            busy_run <= IDLE_ONE_FIELD;
        end else if (idle_busy) begin
            busy_run <= busy_run + 4'h1;
        end else begin
            busy_run <= IDLE_ONE_FIELD;
        end
    end

    load_sign_a: assert property (
        issue_valid && cond_pass && op_class == CLASS_LOAD_LOW
        |=> wr_en && wr_data[CONST_W-1:0] == $past(cst16)
            && wr_data[DATA_W-1:CONST_W] == {CONST_W{wr_data[CONST_W-1]}})
        else $error("low constant load not sign extended");

    neg_result_a: assert property (
        issue_valid && cond_pass && op_class == CLASS_LOGIC
            && opfield == OPF_L_NEG32
        |=> wr_en && DATA_W'(wr_data[DATA_W-1:0] + $past(src2_lo)) == ZERO32)
        else $error("negate result does not cancel source");

    norm_range_a: assert property (
        issue_valid && cond_pass && op_class == CLASS_LOGIC
            && opfield == OPF_L_NORM32
        |=> wr_en && wr_data[NORM_W-1:0] <= NORM32_MAX)
        else $error("normalize count out of range");

    idle_bound_a: assert property (
        busy_run <= IDLE_MAX_FIELD)
        else $error("idle lasted longer than nine cycles");

    idle_end_a: assert property (
        $fell(idle_busy) |-> $past(branch_done)
            || $past(idle_left) == IDLE_ONE_FIELD)
        else $error("idle ended without count or branch");

    idle_unsup_a: assert property (
        idle_valid && !idle_busy && idle_field > IDLE_MAX_FIELD
        |=> idle_unsupported && !idle_busy)
        else $error("oversized idle count not flagged");

    idle_single_a: assert property (
        idle_valid && !idle_busy && idle_field == IDLE_ONE_FIELD
        |=> !idle_busy)
        else $error("single idle stalled the pipeline");

    saturating_add_op_clamp_a: assert property (
        issue_valid && cond_pass && op_class == CLASS_LOGIC
            && opfield == OPF_L_SADD32 && sat32
            && !src1[DATA_W-1] && !src2_lo[DATA_W-1]
        |=> wr_data[DATA_W-1:0] == INT32_MAX ##1 sat_flag)
        else $error("positive overflow not clamped and flagged");

    sat_delay_a: assert property (
        $rose(sat_flag) |-> $past(wr_en) && $past(sat_pending))
        else $error("saturation flag rose without a write");

    sat_sticky_a: assert property (
        sat_flag && !sat_flag_clear |=> sat_flag)
        else $error("saturation flag dropped without a clear");

    cond_fail_a: assert property (
        issue_valid && !cond_pass |=> !wr_en && !sat_pending)
        else $error("failed condition produced a write");

    load_seen_c: cover property (
        issue_valid && cond_pass && op_class == CLASS_LOAD_LOW ##1 wr_en);

    idle_cut_c: cover property (
        idle_busy && branch_done && idle_left != IDLE_ONE_FIELD);

    sat_set_c: cover property ($rose(sat_flag));

    sat_clear_c: cover property (sat_flag && sat_flag_clear ##1 !sat_flag);

endmodule

// ==== reg_file_model.sv ====
`timescale 1ns/1ps
// Destination side of the datapath: records each write that lands.
module reg_file_model
    import const_ops_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic wr_en,
    input wire logic wr_long,
    input wire logic [LONG_W-1:0] wr_data,
    output logic [LONG_W-1:0] last_val,
    output logic last_long,
    output int unsigned wr_count
);
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            last_val <= ZERO40;
            last_long <= 1'b0;
            wr_count <= 0;
        end else if (wr_en) begin
            last_val <= wr_data;
            last_long <= wr_long;
            wr_count <= wr_count + 1;
        end
    end
endmodule

// ==== tb.sv ====
`timescale 1ns/1ps
module tb
    import const_ops_pkg::*;
;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic issue_valid = 1'b0;
    logic cond_pass = 1'b0;
    op_class_t op_class = CLASS_NONE;
    logic [OPF_W-1:0] opfield = '0;
    logic [DATA_W-1:0] src1 = '0;
    logic [LONG_W-1:0] src2 = '0;
    logic [CONST_W-1:0] cst16 = '0;
    logic [IMM_W-1:0] imm5 = '0;
    logic idle_valid = 1'b0;
    logic [IDLE_W-1:0] idle_field = '0;
    logic branch_done = 1'b0;
    logic sat_flag_clear = 1'b0;
    logic wr_en, wr_long, sat_flag, idle_busy, idle_unsupported;
    logic [LONG_W-1:0] wr_data, rf_val;
    logic rf_long;
    int unsigned rf_count;
    int fail_count = 0;
    int checked = 0;
    int pushed = 0;
    int seed = 32'hd41a6461;
    logic [LONG_W:0] expq[$];
    logic [LONG_W:0] last_exp = '0;

    const_logic_sat_ops dut (.clk(clk), .rst_n(rst_n),
        .issue_valid(issue_valid), .cond_pass(cond_pass),
        .op_class(op_class), .opfield(opfield), .src1(src1), .src2(src2),
        .cst16(cst16), .imm5(imm5), .idle_valid(idle_valid),
        .idle_field(idle_field), .branch_done(branch_done),
        .sat_flag_clear(sat_flag_clear), .wr_en(wr_en), .wr_long(wr_long),
        .wr_data(wr_data), .sat_flag(sat_flag), .idle_busy(idle_busy),
        .idle_unsupported(idle_unsupported));

    reg_file_model rf (.clk(clk), .rst_n(rst_n), .wr_en(wr_en),
        .wr_long(wr_long), .wr_data(wr_data), .last_val(rf_val),
        .last_long(rf_long), .wr_count(rf_count));

    initial begin
        forever #10 clk = ~clk;
    end

    ////////////////////////////////////////////////////////////////////////
    task automatic check(input string what, input logic [39:0] seen,
                         input logic [39:0] exp);
        checked++;
        if (seen !== exp) begin
            fail_count++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic stop_test();
        $display("checked %0d mismatches %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    // Presents one instruction; a passing one notes its expected write.
    task automatic issue(input op_class_t c, input logic [6:0] opf,
                         input logic [31:0] a, input logic [39:0] b,
                         input logic [15:0] k, input logic [4:0] im,
                         input logic cp, input logic [40:0] exp);
        @(posedge clk);
        #1;
        issue_valid = 1'b1;
        cond_pass = cp;
        op_class = c;
        opfield = opf;
        src1 = a;
        src2 = b;
        cst16 = k;
        imm5 = im;
        if (cp) begin
            expq.push_back(exp);
            pushed++;
        end
    endtask

    task automatic quiet();
        @(posedge clk);
        #1;
        issue_valid = 1'b0;
        idle_valid = 1'b0;
        sat_flag_clear = 1'b0;
        branch_done = 1'b0;
    endtask

    task automatic idle_test(input logic [3:0] f, input int br,
                             input int exp_n, input logic exp_u);
        int n;
        n = 0;
        @(posedge clk);
        #1;
        idle_valid = 1'b1;
        idle_field = f;
        for (int i = 1; i < 14; i++) begin
            @(posedge clk);
            #1;
            idle_valid = 1'b0;
            if (i < 3) check("unsupported", 40'(idle_unsupported),
                             40'(exp_u && i == 1));
            if (idle_busy === 1'b1) n++;
            branch_done = (i == br);
        end
        check("idle cycles", 40'(n), 40'(exp_n));
        $display("test idle %0d done", f);
    endtask

    function automatic logic [40:0] sat32(input logic signed [40:0] v);
        if (v > 41'sh0_7FFF_FFFF) return {9'h000, INT32_MAX};
        if (v < -41'sh0_8000_0000) return {9'h000, INT32_MIN};
        return {9'h000, v[31:0]};
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Every write is paired with the oldest noted expectation.
    always @(negedge clk) begin
        if (rst_n && wr_en === 1'b1) begin
            if (expq.size() == 0) begin
                check("unexpected write", 40'(wr_en), 40'h0);
            end else begin
                check("wr_long", 40'(wr_long), 40'(expq[0][40]));
                check("wr_data", wr_data, expq[0][39:0]);
                last_exp = expq[0];
                void'(expq.pop_front());
            end
        end
    end

    initial begin
        #(20 * 3000);
        fail_count++;
        stop_test();
    end

    initial begin
        logic [31:0] ra;
        logic [31:0] rb;
        repeat (5) @(posedge clk);
        #1;
        rst_n = 1'b1;
        check("sat after reset", 40'(sat_flag), 40'h0);
        issue(CLASS_LOAD_LOW, 7'h00, 0, 0, 16'hC678, 0, 1,
              41'h0_FFFF_C678);
        idle_valid = 1'b1;
        idle_field = IDLE_ONE_FIELD;
        issue(CLASS_LOAD_LOW, 7'h00, 0, 0, 16'h5678, 0, 1,
              41'h0_0000_5678);
        idle_valid = 1'b0;
        issue(CLASS_LOGIC, OPF_L_NEG32, 0, 40'h5, 0, 0, 1,
              41'h0_FFFF_FFFB);
        issue(CLASS_LOGIC, OPF_L_NEG40, 0, 40'h1, 0, 0, 1,
              41'h1_FF_FFFF_FFFF);
        issue(CLASS_SHIFT, 7'(OPF_S_NEG32), 0, 40'h1, 0, 0, 1,
              41'h0_FFFF_FFFF);
        issue(CLASS_LOGIC, OPF_L_NORM32, 0, 40'h0, 0, 0, 1,
              41'h1F);
        issue(CLASS_LOGIC, OPF_L_NORM32, 0, 40'h1, 0, 0, 1,
              41'h1E);
        issue(CLASS_LOGIC, OPF_L_NORM40, 0, 40'h1, 0, 0, 1,
              41'h26);
        issue(CLASS_LOGIC, OPF_L_NORM40, 0, 40'hFF_FFFF_FFFF, 0, 0, 1,
              41'h27);
        issue(CLASS_NOT, 7'h00, 0, 40'h3A41, 0, 0, 1,
              41'h0_FFFF_C5BE);
        issue(CLASS_LOGIC, OPF_L_OR_REG, 32'h08A3_A49F, 40'h00FF_375A, 0, 0,
              1, 41'h0_08FF_B7DF);
        issue(CLASS_SHIFT, 7'(OPF_S_OR_REG), 32'h08A3_A49F, 40'h00FF_375A, 0,
              0, 1, 41'h0_08FF_B7DF);
        issue(CLASS_LOGIC, OPF_L_OR_IMM, 0, 40'h3A41, 0, 5'h14, 1,
              41'h0_FFFF_FFF5);
        issue(CLASS_SHIFT, 7'(OPF_S_OR_IMM), 0, 40'h3A41, 0, 5'h14, 1,
              41'h0_FFFF_FFF5);
        issue(CLASS_LOGIC, OPF_L_SADD32, 32'h4367_71F2, 40'h5A2E_51A3, 0, 0,
              0, 0);
        issue(CLASS_LOGIC, OPF_L_SADD32, 32'h5A2E_51A3, 40'h012A_3FA2, 0, 0,
              1, 41'h0_5B58_9145);
        issue(CLASS_LOGIC, OPF_L_SADD40, 32'h112A_3FA2, 40'h7C83_39B1, 0, 0,
              1, 41'h1_00_8DAD_7953);
        quiet();
        repeat (2) @(posedge clk);
        #1;
        check("sat unset", 40'(sat_flag), 40'h0);
        $display("test basic ops done");
        issue(CLASS_LOGIC, OPF_L_SADD32, 32'h4367_71F2, 40'h5A2E_51A3, 0, 0,
              1, 41'h0_7FFF_FFFF);
        quiet();
        check("sat early", 40'(sat_flag), 40'h0);
        quiet();
        check("sat set", 40'(sat_flag), 40'h1);
        issue(CLASS_LOGIC, 7'h00, 0, 0, 0, 0, 1, 0);
        pushed--;
        void'(expq.pop_back());
        // An empty class must neither write nor post a clamp.
        issue(CLASS_NONE, OPF_L_SADD32, 32'h7FFF_FFFF, 40'h1, 0, 0, 1, 0);
        pushed--;
        void'(expq.pop_back());
        sat_flag_clear = 1'b1;
        quiet();
        quiet();
        check("sat cleared", 40'(sat_flag), 40'h0);
        issue(CLASS_LOGIC, OPF_L_SADD32, 32'h8000_0000, 40'hFFFF_FFFF, 0, 0,
              1, 41'h0_8000_0000);
        issue(CLASS_LOGIC, OPF_L_SADD40, 32'h0000_0001, 40'h7F_FFFF_FFFF, 0,
              0, 1, 41'h1_7F_FFFF_FFFF);
        issue(CLASS_LOGIC, OPF_L_SADD40, 32'hFFFF_FFFF, 40'h80_0000_0000, 0,
              0, 1, 41'h1_80_0000_0000);
        issue(CLASS_LOGIC, OPF_L_SATURATING_ADD_OP_IMM32, 0, 40'h8000_0000, 0, 5'h1F, 1,
              41'h0_8000_0000);
        issue(CLASS_LOGIC, OPF_L_SATURATING_ADD_OP_IMM40, 0, 40'h7F_FFFF_FFFF, 0, 5'h01,
              1, 41'h1_7F_FFFF_FFFF);
        issue(CLASS_LOGIC, OPF_L_SAT, 0, 40'h00_A190_7321, 0, 0, 1,
              41'h0_7FFF_FFFF);
        issue(CLASS_LOGIC, OPF_L_SAT, 0, 40'hFF_A190_7321, 0, 0, 1,
              41'h0_A190_7321);
        issue(CLASS_LOGIC, OPF_L_SAT, 0, 40'h80_0000_0000, 0, 0, 1,
              41'h0_8000_0000);
        for (int i = 0; i < 24; i++) begin
            ra = $random(seed);
            rb = $random(seed);
            if (i[0]) begin
                issue(CLASS_LOGIC, OPF_L_OR_REG, ra, {8'h00, rb}, 0, 0, 1,
                      {9'h000, ra | rb});
            end else begin
                issue(CLASS_LOGIC, OPF_L_SADD32, ra, {8'h00, rb}, 0, 0, 1,
                      sat32(41'(signed'(ra)) + 41'(signed'(rb))));
            end
        end
        quiet();
        repeat (2) @(posedge clk);
        #1;
        check("sat sticky", 40'(sat_flag), 40'h1);
        $display("test saturation done");
        idle_test(4'h0, 0, 0, 1'b0);
        idle_test(4'h1, 0, 1, 1'b0);
        idle_test(4'h2, 0, 2, 1'b0);
        idle_test(IDLE_MAX_FIELD, 0, 8, 1'b0);
        idle_test(4'h9, 0, 0, 1'b1);
        idle_test(4'hF, 0, 0, 1'b1);
        idle_test(4'h4, 2, 2, 1'b0);
        idle_test(4'h4, 4, 4, 1'b0);
        quiet();
        repeat (3) @(posedge clk);
        #1;
        check("pending", 40'(expq.size()), 40'h0);
        check("writes", 40'(rf_count), 40'(pushed));
        check("rf value", rf_val, last_exp[LONG_W-1:0]);
        check("rf long", 40'(rf_long), 40'(last_exp[LONG_W]));
        stop_test();
    end
endmodule
